/* File: apmc_ctrl.sv */
// Purpose: Power mode state machine with regulator and reserve control
// Assumes: Status inputs and the boost set-point comparator are synchronous levels; wake and battery good comparators are resynchronised
// Notes: Analog loops are outside; this block only drives enables, level selects and status
`timescale 1ns/1ps
module apmc_ctrl
  import apmc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Comparator inputs
  input wire logic wake_above_thr,
  input wire logic battery_monitor_good,
  input wire logic battery_supply_good,
  input wire logic battery_above_boost_set,
  // Regulator status
  input wire logic boost_good,
  input wire logic sensor_buck_good,
  input wire logic logic_buck_good,
  input wire logic [4:0] reg_ov,
  input wire logic [4:0] reg_uv,
  input wire logic uvlo,
  // Straps and arming
  input wire logic logic_supply_select_pin,
  input wire logic arm_safing_req,
  // Host command and configuration levels
  input wire logic host_sleep_cmd,
  input wire logic host_shutdown_cmd,
  input wire logic host_sensor_buck_off_cmd,
  input wire logic host_charge_en,
  input wire logic host_discharge_en,
  input wire logic host_boost_high_sel,
  input wire logic host_sensor_buck_high_sel,
  input wire logic host_safing_en,
  input wire logic host_safing_high_sel,
  input wire logic [2:0] host_fast_slope,
  // Enables
  output logic core_regs_en,
  output logic reserve_boost_en,
  output logic sync_boost_en,
  output logic sensor_buck_en,
  output logic logic_buck_en,
  output logic buck_discharge,
  output logic safing_supply_en,
  output logic charge_src_en,
  output logic discharge_src_en,
  output logic crossover_sw_on,
  output logic crossover_active_out,
  // Levels and status
  output logic sync_boost_high,
  output logic sensor_buck_high,
  output logic logic_buck_low,
  output logic safing_supply_high,
  output logic [2:0] fast_slope,
  output logic reset_n_out,
  output logic [1:0] power_mode
);

  apmc_mode_t mode_r, mode_nxt;
  logic [1:0] wake_s_r, batm_s_r, vin_s_r;
  logic [FILT_W-1:0] filt_cnt_r;
  logic wake_f_r;
  logic [WIN_W-1:0] win_cnt_r;
  logic win_open;
  logic shutdown_r;
  logic [4:0] fault_r;
  logic batt_loss;
  logic xover;

  // Two-flop synchronisers for the wake, battery monitor and battery supply comparator outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      wake_s_r <= SYNC_RST;
      batm_s_r <= SYNC_RST;
      vin_s_r <= SYNC_RST;
    end else begin
      wake_s_r <= {wake_s_r[0], wake_above_thr};
      batm_s_r <= {batm_s_r[0], battery_monitor_good};
      vin_s_r <= {vin_s_r[0], battery_supply_good};
    end
  end

  // Wake filter: a new level must hold for the whole filter time
  always_ff @(posedge clock) begin
    if (rst) begin
      filt_cnt_r <= '0;
      wake_f_r <= 1'b0;
    end else if (wake_s_r[1] == wake_f_r) begin
      filt_cnt_r <= '0;
    end else if (filt_cnt_r == FILT_MAX) begin
      filt_cnt_r <= '0;
      wake_f_r <= wake_s_r[1];
    end else begin
      filt_cnt_r <= filt_cnt_r + 1'b1;
    end
  end

  // Early-wake window counts from active entry
  always_ff @(posedge clock) begin
    if (rst || mode_r != APMC_ACTIVE) begin
      win_cnt_r <= '0;
    end else if (win_open) begin
      win_cnt_r <= win_cnt_r + 1'b1;
    end
  end
  assign win_open = (win_cnt_r < WIN_W'(WAKE_WINDOW_CYC));

  // Shutdown command latch; cleared only on return to off
  always_ff @(posedge clock) begin
    if (rst || mode_r == APMC_OFF) begin
      shutdown_r <= 1'b0;
    end else if (host_shutdown_cmd || (host_sleep_cmd && !wake_f_r && !win_open)) begin
      shutdown_r <= 1'b1;
    end
  end

  // Regulator faults are sticky until the mode drops to off or sleep
  always_ff @(posedge clock) begin
    if (rst || mode_r == APMC_OFF || mode_r == APMC_SLEEP) begin
      fault_r <= '0;
    end else begin
      fault_r <= fault_r | reg_ov | reg_uv;
    end
  end

  assign batt_loss = !vin_s_r[1] || !batm_s_r[1];
  assign xover = batt_loss || shutdown_r;

  // Next mode: only wake, battery, supply, early-wake window and host commands
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      APMC_OFF: begin
        if (wake_f_r) mode_nxt = APMC_SLEEP;
      end
      APMC_SLEEP: begin
        if (!wake_f_r) mode_nxt = APMC_OFF;
        else if (vin_s_r[1]) mode_nxt = APMC_ACTIVE;
      end
      APMC_ACTIVE: begin
        if (!wake_f_r && win_open) mode_nxt = APMC_SLEEP;
        else if (xover) mode_nxt = APMC_PASSIVE;
      end
      APMC_PASSIVE: begin
        if (host_sensor_buck_off_cmd && shutdown_r) mode_nxt = APMC_OFF;
      end
      default: mode_nxt = APMC_OFF;
    endcase
  end

  // Mode register
  always_ff @(posedge clock) begin
    if (rst) mode_r <= APMC_OFF;
    else mode_r <= mode_nxt;
  end

  // Supply enables; sequencing follows the good flags of earlier stages
  always_ff @(posedge clock) begin
    if (rst) begin
      core_regs_en <= 1'b0;
      reserve_boost_en <= 1'b0;
      sync_boost_en <= 1'b0;
      sensor_buck_en <= 1'b0;
      logic_buck_en <= 1'b0;
      buck_discharge <= 1'b0;
      safing_supply_en <= 1'b0;
      reset_n_out <= 1'b0;
    end else begin
      core_regs_en <= mode_nxt != APMC_OFF;
      reserve_boost_en <= mode_nxt == APMC_ACTIVE && !fault_r[0];
      sync_boost_en <= (mode_nxt == APMC_ACTIVE || mode_nxt == APMC_PASSIVE)
        && !battery_above_boost_set && !fault_r[1];
      sensor_buck_en <= (mode_nxt == APMC_ACTIVE || mode_nxt == APMC_PASSIVE)
        && boost_good && !uvlo && !fault_r[2];
      logic_buck_en <= (mode_nxt == APMC_ACTIVE || mode_nxt == APMC_PASSIVE)
        && sensor_buck_good && !uvlo && !fault_r[3];
      buck_discharge <= uvlo;
      safing_supply_en <= (mode_nxt == APMC_ACTIVE || mode_nxt == APMC_PASSIVE)
        && (host_safing_en || arm_safing_req) && !fault_r[4];
      reset_n_out <= logic_buck_en && logic_buck_good && !uvlo;
    end
  end

  // Reserve current sources and crossover outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      charge_src_en <= 1'b0;
      discharge_src_en <= 1'b0;
      crossover_sw_on <= 1'b0;
      crossover_active_out <= 1'b0;
    end else begin
      charge_src_en <= mode_nxt == APMC_ACTIVE && host_charge_en;
      discharge_src_en <= mode_nxt == APMC_PASSIVE && shutdown_r
        && host_discharge_en;
      crossover_sw_on <= mode_nxt == APMC_PASSIVE && xover;
      crossover_active_out <= mode_nxt == APMC_PASSIVE && xover;
    end
  end

  // Level selects; fast-slope bits are passed straight from the host
  always_ff @(posedge clock) begin
    if (rst) begin
      sync_boost_high <= 1'b0;
      sensor_buck_high <= 1'b0;
      logic_buck_low <= 1'b0;
      safing_supply_high <= 1'b0;
      fast_slope <= '0;
      power_mode <= APMC_OFF;
    end else begin
      sync_boost_high <= host_boost_high_sel;
      sensor_buck_high <= host_sensor_buck_high_sel;
      logic_buck_low <= logic_supply_select_pin;
      safing_supply_high <= host_safing_high_sel;
      fast_slope <= host_fast_slope;
      power_mode <= mode_nxt;
    end
  end

  // Off mode keeps core regs, sync boost and logic buck disabled
  property p_off_quiet;
    @(posedge clock) disable iff (rst)
      (power_mode == APMC_OFF) |-> !core_regs_en && !sync_boost_en && !logic_buck_en;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("supply on in off mode");

  property p_sleep_core;
    @(posedge clock) disable iff (rst)
      (power_mode == APMC_SLEEP) |-> core_regs_en && !sync_boost_en && !sensor_buck_en;
  endproperty
  a_sleep_core: assert property (p_sleep_core) else $error("sleep enables wrong");

  property p_xover_pin;
    @(posedge clock) disable iff (rst) crossover_active_out == crossover_sw_on;
  endproperty
  a_xover_pin: assert property (p_xover_pin) else $error("crossover pin mismatch");

  property p_xover_cause;
    @(posedge clock) disable iff (rst)
      crossover_sw_on |-> $past(xover);
  endproperty
  a_xover_cause: assert property (p_xover_cause) else $error("crossover without cause");

  property p_uvlo;
    @(posedge clock) disable iff (rst)
      uvlo |=> !sensor_buck_en && !logic_buck_en && buck_discharge;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("bucks on during lockout");

  property p_boost_high;
    @(posedge clock) disable iff (rst) battery_above_boost_set |=> !sync_boost_en;
  endproperty
  a_boost_high: assert property (p_boost_high) else $error("boost on above set point");

  property p_fault;
    @(posedge clock) disable iff (rst) reg_ov[2] |=> ##1 !sensor_buck_en;
  endproperty
  a_fault: assert property (p_fault) else $error("faulted buck stays on");

  sequence s_active_low_wake;
    power_mode == APMC_ACTIVE && win_open && !wake_f_r;
  endsequence
  property p_early_sleep;
    @(posedge clock) disable iff (rst) s_active_low_wake |=> power_mode == APMC_SLEEP;
  endproperty
  a_early_sleep: assert property (p_early_sleep) else $error("early wake loss ignored");

  property p_reset_order;
    @(posedge clock) disable iff (rst) $rose(reset_n_out) |-> $past(logic_buck_en);
  endproperty
  a_reset_order: assert property (p_reset_order) else $error("reset before logic buck");

  property p_charge;
    @(posedge clock) disable iff (rst) charge_src_en |-> $past(host_charge_en);
  endproperty
  a_charge: assert property (p_charge) else $error("charge without host");

endmodule : apmc_ctrl

/* File: apmc_pkg.sv */
// Purpose: Shared constants and types for the airbag power mode controller
// Assumes: 100 MHz logic clock, synchronous active-high reset
// Notes: Timing figures kept in their own unit, cycle counts derived here
package apmc_pkg;
  localparam int CLK_MHZ = 100;
  // Early-wake window after entering active mode, in microseconds
  localparam int WAKE_WINDOW_US = 9000;
  localparam int WAKE_WINDOW_CYC = WAKE_WINDOW_US * CLK_MHZ;
  // Wake glitch filter, in nanoseconds
  localparam int WAKE_FILT_NS = 100;
  localparam int WAKE_FILT_CYC = (WAKE_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_W = 8;
  localparam int WIN_W = 20;
  localparam logic [FILT_W-1:0] FILT_MAX = FILT_W'(WAKE_FILT_CYC - 1);
  localparam logic [1:0] SYNC_RST = 2'h0;

  // Gray-coded power modes along off -> sleep -> active -> passive
  typedef enum logic [1:0] {
    APMC_OFF = 2'h0,
    APMC_SLEEP = 2'h1,
    APMC_ACTIVE = 2'h3,
    APMC_PASSIVE = 2'h2
  } apmc_mode_t;
endpackage : apmc_pkg

/* File: apmc_reg_model.sv */
// Purpose: Regulator side responder for the power mode controller bench
// Assumes: Each good flag follows its enable after DLY cycles of ramp
// Notes: A flag drops on the clock after its enable falls, like a real collapse
`timescale 1ns/1ps
module apmc_reg_model #(
  parameter int DLY = 4
) (
  // Clock
  input wire logic clock,
  // Enables from the controller
  input wire logic sync_boost_en,
  input wire logic sensor_buck_en,
  input wire logic logic_buck_en,
  // Good flags back
  output logic boost_good,
  output logic sensor_buck_good,
  output logic logic_buck_good
);
  int cnt [3] = '{0, 0, 0};
  // Ramp counters; an instant good would hide start ordering slips
  always @(posedge clock) begin
    cnt[0] <= sync_boost_en ? cnt[0] + 1 : 0;
    cnt[1] <= sensor_buck_en ? cnt[1] + 1 : 0;
    cnt[2] <= logic_buck_en ? cnt[2] + 1 : 0;
  end
  // Good once the ramp has run
  assign boost_good = (cnt[0] >= DLY);
  assign sensor_buck_good = (cnt[1] >= DLY);
  assign logic_buck_good = (cnt[2] >= DLY);
endmodule : apmc_reg_model

/* File: tb_top.sv */
// Purpose: Self-checking bench for the power mode controller
// Assumes: Outputs settle within a few cycles of each mode change
// Notes: Host levels come from a fixed seed
`timescale 1ns/1ps
module tb_top;
  import apmc_pkg::*;
  logic clock, rst, wake, bmon, sup, above, uvlo, sel, arm;
  logic sleep_c, shut_c, skoff_c, h_chg, h_dchg, h_bh, h_skh, h_saf, h_safh;
  logic [2:0] h_fs, fs;
  logic [4:0] ov, uv;
  logic core, rbst, sbst, sbk, lbk, bdis, saf, chg, dchg, xsw, xact;
  logic sbh, skh, lbl, safh, rstn, g0, g1, g2;
  logic [1:0] mode;
  int n_fail = 0;
  int comparisons = 0;
  int em;
  int glitch;
  apmc_ctrl apmc_ctrl_inst (.clock(clock), .rst(rst), .wake_above_thr(wake),
    .battery_monitor_good(bmon), .battery_supply_good(sup),
    .battery_above_boost_set(above), .boost_good(g0), .sensor_buck_good(g1),
    .logic_buck_good(g2), .reg_ov(ov), .reg_uv(uv), .uvlo(uvlo),
    .logic_supply_select_pin(sel), .arm_safing_req(arm), .host_sleep_cmd(sleep_c),
    .host_shutdown_cmd(shut_c), .host_sensor_buck_off_cmd(skoff_c),
    .host_charge_en(h_chg), .host_discharge_en(h_dchg), .host_boost_high_sel(h_bh),
    .host_sensor_buck_high_sel(h_skh), .host_safing_en(h_saf),
    .host_safing_high_sel(h_safh), .host_fast_slope(h_fs), .core_regs_en(core),
    .reserve_boost_en(rbst), .sync_boost_en(sbst), .sensor_buck_en(sbk),
    .logic_buck_en(lbk), .buck_discharge(bdis), .safing_supply_en(saf),
    .charge_src_en(chg), .discharge_src_en(dchg), .crossover_sw_on(xsw),
    .crossover_active_out(xact), .sync_boost_high(sbh), .sensor_buck_high(skh),
    .logic_buck_low(lbl), .safing_supply_high(safh), .fast_slope(fs),
    .reset_n_out(rstn), .power_mode(mode));
  apmc_reg_model #(.DLY(4)) apmc_reg_model_inst (.clock(clock), .sync_boost_en(sbst),
    .sensor_buck_en(sbk), .logic_buck_en(lbk), .boost_good(g0),
    .sensor_buck_good(g1), .logic_buck_good(g2));
  // Free-running 100 MHz clock
  always #5 clock = ~clock;
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // Model mode em; poll the design under a bound, then compare
  task automatic wait_mode(input int m);
    em = m;
    for (int i = 0; i < 60 && mode !== 2'(em); i++) tick(1);
    cmp(8'(mode), 8'(em));
  endtask : wait_mode
  task automatic do_reset();
    @(posedge clock);
    rst <= 1'b1;
    {wake, sup, above, uvlo, ov, uv, shut_c, skoff_c, h_dchg} <= '0;
    bmon <= 1'b1;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    tick(1);
    cmp({core, sbst, xsw, xact, rstn, mode}, 8'h00);
  endtask : do_reset
  task automatic go_active();
    @(posedge clock);
    wake <= 1'b1;
    wait_mode(1);
    cmp({core, sbst}, 8'h02);
    @(posedge clock);
    sup <= 1'b1;
    wait_mode(3);
    cmp({sbk, lbk, rstn}, 8'h00);
    tick(40);
    cmp({rbst, sbst, sbk, lbk, rstn}, 8'h1F);
  endtask : go_active
  task automatic end_sim();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // Watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge clock);
    n_fail++;
    end_sim();
  end
  // Main sequence
  initial begin
    {clock, wake, sup, above, uvlo, sel, arm, sleep_c, shut_c, skoff_c} = '0;
    {h_chg, h_dchg, h_bh, h_skh, h_saf, h_safh, h_fs, ov, uv} = '0;
    rst = 1'b1;
    bmon = 1'b1;
    void'($urandom(32'hF25B87FB));
    do_reset();
    // Short wake pulse: mode must never leave off, so watch every cycle
    @(posedge clock);
    wake <= 1'b1;
    tick(5);
    @(posedge clock);
    wake <= 1'b0;
    glitch = 0;
    for (int i = 0; i < 30; i++) begin
      tick(1);
      if (mode !== 2'h0) glitch = 1;
    end
    cmp(8'(glitch), 8'h00);
    go_active();
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      {h_chg, h_bh, h_skh, h_saf, h_safh, arm, sel, h_fs} <= 10'($urandom);
      tick(5);
      cmp({chg, sbh, skh, lbl}, {4'h0, h_chg, h_bh, h_skh, sel});
      cmp({safh, saf, fs}, {3'h0, h_safh, h_saf | arm, h_fs});
    end
    @(posedge clock);
    sleep_c <= 1'b1;
    tick(5);
    cmp(8'(mode), 8'h03);
    @(posedge clock);
    sleep_c <= 1'b0;
    above <= 1'b1;
    tick(5);
    cmp(8'(sbst), 8'h00);
    @(posedge clock);
    above <= 1'b0;
    tick(3);
    cmp(8'(sbst), 8'h01);
    @(posedge clock);
    wake <= 1'b0;
    wait_mode(1);
    wait_mode(0);
    $display("test early wake and config done");
    do_reset();
    go_active();
    @(posedge clock);
    h_chg <= 1'b1;
    shut_c <= 1'b1;
    tick(1);
    @(posedge clock);
    shut_c <= 1'b0;
    wait_mode(2);
    tick(5);
    cmp({xsw, xact, chg, rbst, dchg}, 8'h18);
    @(posedge clock);
    h_dchg <= 1'b1;
    wake <= 1'b0;
    tick(5);
    cmp(8'(dchg), 8'h01);
    @(posedge clock);
    skoff_c <= 1'b1;
    wait_mode(0);
    @(posedge clock);
    skoff_c <= 1'b0;
    $display("test shutdown done");
    for (int k = 0; k < 2; k++) begin
      do_reset();
      go_active();
      @(posedge clock);
      if (k == 0) sup <= 1'b0;
      else bmon <= 1'b0;
      wait_mode(2);
      tick(3);
      cmp({xsw, xact}, 8'h03);
    end
    $display("test battery loss done");
    do_reset();
    go_active();
    // Lockout first, while the boost still feeds the bucks, so only it can stop them
    @(posedge clock);
    uvlo <= 1'b1;
    tick(5);
    cmp({sbst, sbk, lbk, bdis}, 8'h09);
    @(posedge clock);
    uvlo <= 1'b0;
    tick(20);
    cmp({sbk, lbk, bdis}, 8'h06);
    @(posedge clock);
    ov <= 5'h04;
    tick(5);
    cmp({sbst, sbk}, 8'h02);
    @(posedge clock);
    uv <= 5'h02;
    tick(5);
    cmp(8'(sbst), 8'h00);
    $display("test faults done");
    end_sim();
  end
endmodule : tb_top
